// File: logic/led_behavior_sequencer.sv
// Purpose: eight-channel LED behaviour sequencer with PWM outputs
// Assumes: one AHB-Lite slave on the bus, touch levels asynchronous
// Notes: each bus transfer takes one wait state
// Notes on behaviour
// - low behaviour register holds LED4..LED1 selectors, two bits each, LED1 lowest
// - high behaviour register holds LED8..LED5 selectors, two bits each, LED5 lowest
// - direct: touch or drive bit lights the LED, release or clear darkens it
// - pulse one: programmed pulse count after trigger, each pulse min-max-min, no stop
// - bit 7 of pulse one period picks touch/set or release/clear as start
// - pulse two: pulse while held, then programmed further pulses, rest at minimum
// - breathe: ramp min to max and back, half period each, until release
// - pulse one period: bits 6:0 at 32 ms each, 0 and 1 both 32 ms
// - pulse two period: bits 6:0 at 32 ms each, bit 7 unused
// - periods too short are stretched to the shortest period PWM allows
// - PWM rate follows mode, period and duty limits; direct uses highest rate (here PWM runs at one fixed 100-cycle rate in every mode)
// - polarity one gives non-inverted output, zero gives inverted output
// - unlinked LED: drive bit set acts as touch, clear acts as release
// - three-bit repeat codes 000 to 111 select one to eight pulses
`timescale 1ns/1ps
module led_behavior_sequencer #(
  parameter int MS_CYCLES = led_seq_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic        REF_CLK_IN,
  input  wire logic        RESETN_IN,
  // AHB-Lite slave
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic      [31:0] HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  // sensor and LED pins
  input  wire logic [7:0]  TOUCH_IN,
  output logic      [7:0]  LED_OUT
);

  logic [7:0]             behavior_low;
  logic [7:0]             behavior_high;
  logic [7:0]             pulse_one_period_cfg;
  logic [7:0]             pulse_two_period_cfg;
  logic [7:0]             breathe_period_cfg;
  logic [7:0]             pulse_repeat_count;
  logic [7:0]             duty_limits;
  logic [7:0]             led_link;
  logic [7:0]             led_output_polarity;
  logic [7:0]             led_output_drive_bit;
  logic [7:0]             touch_s1;
  logic [7:0]             touch_s2;
  logic [7:0]             running;
  logic [7:0]             lit;
  logic [17:0]            ms_cnt;
  logic                   ms_tick;
  logic [4:0]             ms_sub;
  logic                   tick32;
  logic [6:0]             pwm_cnt;
  logic [6:0]             max_pct;
  logic [6:0]             min_pct;
  logic [15:0]            led_behavior_select;
  logic                   pulse_one_trigger_edge;
  logic [2:0]             repeat_one;
  logic [2:0]             repeat_two;
  led_seq_pkg::bus_req_s  req;
  logic                   pend;
  logic                   take;
  logic [31:0]            rd_word;

  // bus slave
  assign take = HSEL_IN & HTRANS_IN[1] & HREADY_IN;

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      req           <= '0;
      pend          <= 1'b0;
      HREADYOUT_OUT <= 1'b1;
    end else if (take) begin
      req.idx       <= HADDR_IN[9:2];
      req.write     <= HWRITE_IN;
      pend          <= 1'b1;
      HREADYOUT_OUT <= 1'b0;
    end else if (pend) begin
      pend          <= 1'b0;
      HREADYOUT_OUT <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      HRESP_OUT <= 1'b0;
    end else begin
      HRESP_OUT <= 1'b0;
    end
  end

  always_comb begin
    rd_word = '0;
    unique case (req.idx)
      led_seq_pkg::IDX_BEHAVIOR_LOW:  rd_word[7:0] = behavior_low;
      led_seq_pkg::IDX_BEHAVIOR_HIGH: rd_word[7:0] = behavior_high;
      led_seq_pkg::IDX_PULSE_ONE:     rd_word[7:0] = pulse_one_period_cfg;
      led_seq_pkg::IDX_PULSE_TWO:     rd_word[7:0] = pulse_two_period_cfg;
      led_seq_pkg::IDX_BREATHE:       rd_word[7:0] = breathe_period_cfg;
      led_seq_pkg::IDX_REPEAT:        rd_word[7:0] = pulse_repeat_count;
      led_seq_pkg::IDX_DUTY:          rd_word[7:0] = duty_limits;
      led_seq_pkg::IDX_LINK:          rd_word[7:0] = led_link;
      led_seq_pkg::IDX_POLARITY:      rd_word[7:0] = led_output_polarity;
      led_seq_pkg::IDX_DRIVE:         rd_word[7:0] = led_output_drive_bit;
      led_seq_pkg::IDX_STATUS:        rd_word[15:0] = {LED_OUT, running};
      default:                        rd_word = '0;
    endcase
  end

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      HRDATA_OUT <= '0;
    end else if (pend && !req.write) begin
      HRDATA_OUT <= rd_word;
    end
  end

  // register writes land in the first data-phase cycle
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      behavior_low         <= led_seq_pkg::RST_BEHAVIOR;
      behavior_high        <= led_seq_pkg::RST_BEHAVIOR;
      pulse_one_period_cfg <= led_seq_pkg::RST_PULSE_ONE;
      pulse_two_period_cfg <= led_seq_pkg::RST_PULSE_TWO;
      breathe_period_cfg   <= led_seq_pkg::RST_BREATHE;
      pulse_repeat_count   <= led_seq_pkg::RST_REPEAT;
      duty_limits          <= led_seq_pkg::RST_DUTY;
      led_link             <= led_seq_pkg::RST_LOOSE;
      led_output_polarity  <= led_seq_pkg::RST_LOOSE;
      led_output_drive_bit <= led_seq_pkg::RST_LOOSE;
    end else if (pend && req.write) begin
      unique case (req.idx)
        led_seq_pkg::IDX_BEHAVIOR_LOW:  behavior_low <= HWDATA_IN[7:0];
        led_seq_pkg::IDX_BEHAVIOR_HIGH: behavior_high <= HWDATA_IN[7:0];
        led_seq_pkg::IDX_PULSE_ONE:     pulse_one_period_cfg <= HWDATA_IN[7:0];
        led_seq_pkg::IDX_PULSE_TWO:     pulse_two_period_cfg <= {1'b0, HWDATA_IN[6:0]};
        led_seq_pkg::IDX_BREATHE:       breathe_period_cfg <= {1'b0, HWDATA_IN[6:0]};
        led_seq_pkg::IDX_REPEAT:        pulse_repeat_count <= {2'b00, HWDATA_IN[5:0]};
        led_seq_pkg::IDX_DUTY:          duty_limits <= HWDATA_IN[7:0];
        led_seq_pkg::IDX_LINK:          led_link <= HWDATA_IN[7:0];
        led_seq_pkg::IDX_POLARITY:      led_output_polarity <= HWDATA_IN[7:0];
        led_seq_pkg::IDX_DRIVE:         led_output_drive_bit <= HWDATA_IN[7:0];
        default:                        ;
      endcase
    end
  end

  // sensor synchroniser
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      touch_s1 <= '0;
      touch_s2 <= '0;
    end else begin
      touch_s1 <= TOUCH_IN;
      touch_s2 <= touch_s1;
    end
  end

  // 1 ms and 32 ms timebase
  assign ms_tick = (ms_cnt == 18'(MS_CYCLES - 1));
  assign tick32  = ms_tick && (ms_sub == led_seq_pkg::TICK_LAST_MS);

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ms_cnt <= '0;
      ms_sub <= '0;
    end else begin
      ms_cnt <= ms_tick ? '0 : ms_cnt + 18'h00001;
      if (ms_tick) begin
        ms_sub <= ms_sub + 5'h01;
      end
    end
  end

  // PWM runs at the full rate in every mode
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      pwm_cnt <= '0;
    end else begin
      pwm_cnt <= (pwm_cnt == led_seq_pkg::PWM_LAST) ? '0 : pwm_cnt + 7'h01;
    end
  end

  assign led_behavior_select    = {behavior_high, behavior_low};
  assign pulse_one_trigger_edge = pulse_one_period_cfg[led_seq_pkg::TRIG_BIT];
  assign repeat_one = pulse_repeat_count[led_seq_pkg::CNT_ONE_LSB +: 3];
  assign repeat_two = pulse_repeat_count[led_seq_pkg::CNT_TWO_LSB +: 3];
  assign max_pct = led_seq_pkg::DUTY_PCT[duty_limits[led_seq_pkg::MAX_LSB +: 4]];
  assign min_pct = (duty_limits[3:0] == 4'h0) ? 7'h00 : led_seq_pkg::DUTY_PCT[duty_limits[3:0] - 4'h1];

  for (genvar i = 0; i < 8; i++) begin : g_ch
    led_seq_pkg::led_mode_e mode;
    led_seq_pkg::ch_state_e state;
    logic                   act;
    logic                   act_q;
    logic                   rise;
    logic                   fall;
    logic                   start_one;
    logic [6:0]             per_set;
    logic [6:0]             per_eff;
    logic [6:0]             tick_cnt;
    logic [2:0]             remain;
    logic                   period_end;
    logic [11:0]            pos;
    logic [10:0]            half;
    logic [10:0]            t;
    logic [18:0]            lhs;
    logic [18:0]            rhs;

    assign mode = led_seq_pkg::led_mode_e'(led_behavior_select[2*i +: 2]);
    assign act  = led_link[i] ? touch_s2[i] : led_output_drive_bit[i];
    assign rise = act & ~act_q;
    assign fall = ~act & act_q;
    assign start_one = pulse_one_trigger_edge ? fall : rise;

    always_comb begin
      unique case (mode)
        led_seq_pkg::MODE_PULSE_ONE: per_set = pulse_one_period_cfg[6:0];
        led_seq_pkg::MODE_PULSE_TWO: per_set = pulse_two_period_cfg[6:0];
        led_seq_pkg::MODE_BREATHE:   per_set = breathe_period_cfg[6:0];
        led_seq_pkg::MODE_DIRECT:    per_set = 7'h01;
      endcase
    end

    // settings 0 and 1 both mean one tick
    assign per_eff    = (per_set < 7'h02) ? 7'h01 : per_set;
    assign period_end = tick32 && (tick_cnt >= per_eff - 7'h01);
    assign half       = {per_eff, 4'h0};
    assign pos        = {tick_cnt, ms_sub};

    always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
        act_q <= 1'b0;
      end else begin
        act_q <= act;
      end
    end

    always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
        state    <= led_seq_pkg::ST_IDLE;
        tick_cnt <= '0;
        remain   <= '0;
      end else begin
        unique case (state)
          led_seq_pkg::ST_IDLE: begin
            tick_cnt <= '0;
            if (mode == led_seq_pkg::MODE_PULSE_ONE && start_one) begin
              state  <= led_seq_pkg::ST_TAIL;
              remain <= repeat_one;
            end else if ((mode == led_seq_pkg::MODE_PULSE_TWO || mode == led_seq_pkg::MODE_BREATHE) && rise) begin
              state <= led_seq_pkg::ST_RUN;
            end
          end
          led_seq_pkg::ST_RUN: begin
            if (mode == led_seq_pkg::MODE_DIRECT || mode == led_seq_pkg::MODE_PULSE_ONE) begin
              state <= led_seq_pkg::ST_IDLE;
            end else if (fall && mode == led_seq_pkg::MODE_PULSE_TWO) begin
              state    <= led_seq_pkg::ST_TAIL;
              remain   <= repeat_two;
              tick_cnt <= '0;
            end else if (fall) begin
              state <= led_seq_pkg::ST_IDLE;
            end else if (period_end) begin
              tick_cnt <= '0;
            end else if (tick32) begin
              tick_cnt <= tick_cnt + 7'h01;
            end
          end
          led_seq_pkg::ST_TAIL: begin
            // pulse one has no stop trigger, so the sensor is ignored here
            if (period_end) begin
              tick_cnt <= '0;
              if (remain == 3'h0) begin
                state <= led_seq_pkg::ST_IDLE;
              end else begin
                remain <= remain - 3'h1;
              end
            end else if (tick32) begin
              tick_cnt <= tick_cnt + 7'h01;
            end
          end
          default: state <= led_seq_pkg::ST_IDLE;
        endcase
      end
    end

    // ramp position: rises over the first half period, falls over the second
    always_comb begin
      if (mode == led_seq_pkg::MODE_DIRECT) begin
        t = act ? half : 11'h000;
      end else if (state == led_seq_pkg::ST_IDLE) begin
        t = 11'h000;
      end else if (pos < {1'b0, half}) begin
        t = pos[10:0];
      end else begin
        t = 11'({per_eff, 5'h00} - pos);
      end
    end

    // duty = min + (max - min) * t / half, compared without a divider
    assign lhs = 19'(pwm_cnt * half);
    assign rhs = 19'(min_pct * half) + 19'((max_pct - min_pct) * t);
    assign lit[i]     = (lhs < rhs);
    assign running[i] = (state != led_seq_pkg::ST_IDLE);
  end

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      LED_OUT <= '0;
    end else begin
      LED_OUT <= ~(lit ^ led_output_polarity);
    end
  end

endmodule // led_behavior_sequencer

// File: logic/led_seq_pkg.sv
// Purpose: shared constants and types of the LED behaviour sequencer
// Assumes: AHB-Lite register port, 200 MHz reference clock
// Notes: a register index times four is its byte address
package led_seq_pkg;

  // register indices
  localparam logic [7:0] IDX_BEHAVIOR_LOW  = 8'h81;
  localparam logic [7:0] IDX_BEHAVIOR_HIGH = 8'h82;
  localparam logic [7:0] IDX_PULSE_ONE     = 8'h84;
  localparam logic [7:0] IDX_PULSE_TWO     = 8'h85;
  localparam logic [7:0] IDX_BREATHE       = 8'h86;
  localparam logic [7:0] IDX_REPEAT        = 8'h88;
  localparam logic [7:0] IDX_DUTY          = 8'h93;
  localparam logic [7:0] IDX_STATUS        = 8'h70;
  localparam logic [7:0] IDX_LINK          = 8'h72;
  localparam logic [7:0] IDX_POLARITY      = 8'h73;
  localparam logic [7:0] IDX_DRIVE         = 8'h74;

  // reset values
  localparam logic [7:0] RST_BEHAVIOR  = 8'h00;
  localparam logic [7:0] RST_PULSE_ONE = 8'h20;
  localparam logic [7:0] RST_PULSE_TWO = 8'h14;
  localparam logic [7:0] RST_BREATHE   = 8'h5D;
  localparam logic [7:0] RST_REPEAT    = 8'h04;
  localparam logic [7:0] RST_DUTY      = 8'hF0;
  localparam logic [7:0] RST_LOOSE     = 8'h00;

  // field positions
  localparam int TRIG_BIT    = 7;
  localparam int CNT_ONE_LSB = 0;
  localparam int CNT_TWO_LSB = 3;
  localparam int MAX_LSB     = 4;

  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int TICK_MS       = 32;
  localparam logic [4:0] TICK_LAST_MS = 5'(TICK_MS - 1);
  localparam logic [6:0] PWM_LAST     = 7'h63;

  // duty percentages per 4-bit code; a minimum code k uses entry k-1
  localparam logic [6:0] DUTY_PCT [16] = '{
    7'h07, 7'h09, 7'h0B, 7'h0E, 7'h11, 7'h14, 7'h17, 7'h1A,
    7'h1E, 7'h23, 7'h28, 7'h2E, 7'h35, 7'h3F, 7'h4D, 7'h64};

  typedef enum logic [1:0] {
    MODE_DIRECT    = 2'b00,
    MODE_PULSE_ONE = 2'b01,
    MODE_PULSE_TWO = 2'b10,
    MODE_BREATHE   = 2'b11
  } led_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_TAIL = 2'b11
  } ch_state_e;

  typedef struct packed {
    logic [7:0] idx;
    logic       write;
  } bus_req_s;

endpackage

// File: verif/led_behavior_sequencer_checker.sv
// Purpose: bus-side protocol and read-value checks of the LED sequencer
// Assumes: one slave, HREADY_IN tied to HREADYOUT_OUT
// Notes: sees only top-level ports
`timescale 1ns/1ps
module led_seq_checker (
  // clock and reset
  input wire logic        REF_CLK_IN,
  input wire logic        RESETN_IN,
  // bus
  input wire logic        HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0]  HTRANS_IN,
  input wire logic        HWRITE_IN,
  input wire logic        HREADY_IN,
  input wire logic [31:0] HRDATA_OUT,
  input wire logic        HREADYOUT_OUT,
  input wire logic        HRESP_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  logic       take;
  logic       rd_pend;
  logic [7:0] rd_idx;
  logic       cfg_idx;
  logic       known_idx;
  assign take = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
  assign cfg_idx = rd_idx inside {led_seq_pkg::IDX_BEHAVIOR_LOW, led_seq_pkg::IDX_BEHAVIOR_HIGH,
                                  led_seq_pkg::IDX_PULSE_ONE, led_seq_pkg::IDX_PULSE_TWO};
  assign known_idx = cfg_idx | (rd_idx inside {led_seq_pkg::IDX_BREATHE, led_seq_pkg::IDX_REPEAT,
    led_seq_pkg::IDX_DUTY, led_seq_pkg::IDX_STATUS, led_seq_pkg::IDX_LINK, led_seq_pkg::IDX_POLARITY,
    led_seq_pkg::IDX_DRIVE});
  // read data phase tracker
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rd_pend <= 1'b0;
      rd_idx  <= 8'h00;
    end else begin
      rd_pend <= take & ~HWRITE_IN;
      rd_idx  <= HADDR_IN[9:2];
    end
  end
  a_resp_okay: assert property (HRESP_OUT == 1'b0) else $error("response not okay");
  a_take_wait: assert property (take |=> !HREADYOUT_OUT) else $error("no wait state after transfer");
  a_wait_single: assert property (!HREADYOUT_OUT |=> HREADYOUT_OUT) else $error("wait state too long");
  a_ready_idle: assert property (!take && HREADYOUT_OUT |=> HREADYOUT_OUT) else $error("stray wait state");
  a_rdata_hold: assert property (!$stable(HRDATA_OUT) |-> $past(rd_pend)) else $error("read data moved");
  a_rdata_upper: assert property (HRDATA_OUT[31:16] == 16'h0000) else $error("upper read bits set");
  a_cfg_narrow: assert property (rd_pend && cfg_idx |=> HRDATA_OUT[31:8] == 24'h000000)
    else $error("config read too wide");
  a_p2_top_zero: assert property (rd_pend && rd_idx == led_seq_pkg::IDX_PULSE_TWO |=> !HRDATA_OUT[7])
    else $error("unused period bit reads one");
  a_unmapped_zero: assert property (rd_pend && !known_idx |=> HRDATA_OUT == 32'h00000000)
    else $error("unmapped read not zero");
  c_write: cover property (take && HWRITE_IN);
  c_p2_read: cover property (rd_pend && rd_idx == led_seq_pkg::IDX_PULSE_TWO);
  c_unmapped: cover property (rd_pend && !known_idx);
endmodule // led_seq_checker

// File: verif/led_load_model.sv
// Purpose: external LED loads, counting lit cycles per pin
// Assumes: a pin is lit when its level equals its polarity bit
// Notes: clr_in restarts every count
`timescale 1ns/1ps
module led_load_model (
  // control
  input  wire logic       clk_in,
  input  wire logic       clr_in,
  // pins
  input  wire logic [7:0] led_in,
  input  wire logic [7:0] pol_in,
  output logic      [7:0] lit_cnt_out [8]
);
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 8; i++) begin
      if (clr_in) begin
        lit_cnt_out[i] <= 8'h00;
      end else if (led_in[i] == pol_in[i]) begin
        lit_cnt_out[i] <= lit_cnt_out[i] + 8'h01;
      end
    end
  end
endmodule // led_load_model

// File: verif/tb_led_behavior_sequencer.sv
// Purpose: self-checking bench of the LED sequencer
// Assumes: 10 cycles per ms, so a 32 ms tick is 320 cycles
// Notes: status bit 0 shows LED1 running
`timescale 1ns/1ps
module tb_led_behavior_sequencer;
  localparam int MSC  = 10;
  localparam int TICK = 32 * MSC;
  logic        clk = 1'b0;
  logic        rstn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [7:0]  touch;
  logic [7:0]  led;
  logic [7:0]  pol;
  logic        clr;
  logic [7:0]  lit_cnt [8];
  int          cyc = 0;
  int          err_total = 0;
  int          check_count = 0;
  int          el;
  int          n;
  int          mx;
  int          mn;
  logic [31:0] d;
  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  led_behavior_sequencer #(.MS_CYCLES(MSC)) led_behavior_sequencer_i (.REF_CLK_IN(clk), .RESETN_IN(rstn),
    .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize),
    .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
    .HRESP_OUT(hresp), .TOUCH_IN(touch), .LED_OUT(led));
  led_load_model led_load_model_i (.clk_in(clk), .clr_in(clr), .led_in(led), .pol_in(pol),
    .lit_cnt_out(lit_cnt));
  task automatic tally_and_finish();
    if (err_total == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic give_up();
    err_total++;
    tally_and_finish();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 100);
    if (hready !== 1'b1) give_up();
  endtask
  // one single transfer; called just after a rising edge
  task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
    htrans <= 2'b10;
    haddr  <= {22'h000000, idx, 2'b00};
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    wait_rdy();
    d = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    xfer(idx, 1'b1, wd);
  endtask
  task automatic chk_rd(input logic [7:0] idx, input logic [7:0] exp);
    xfer(idx, 1'b0, 8'h00);
    chk(d, {24'h000000, exp});
  endtask
  task automatic poll(input logic v, input int lim);
    int t0;
    t0 = cyc;
    do begin
      xfer(led_seq_pkg::IDX_STATUS, 1'b0, 8'h00);
      if (cyc - t0 > lim) give_up();
    end while (d[0] !== v);
    el = cyc - t0;
  endtask
  // clear is held long enough for a touch to pass the synchroniser and the pin flop
  task automatic lit_of(input int i);
    clr <= 1'b1;
    repeat (4) @(posedge clk);
    clr <= 1'b0;
    repeat (101) @(posedge clk);
    n = lit_cnt[i];
  endtask
  task automatic t_reset();
    @(posedge clk);
    chk({24'h000000, led}, 32'h000000FF);
    chk_rd(led_seq_pkg::IDX_BEHAVIOR_LOW, led_seq_pkg::RST_BEHAVIOR);
    chk_rd(led_seq_pkg::IDX_BEHAVIOR_HIGH, led_seq_pkg::RST_BEHAVIOR);
    chk_rd(led_seq_pkg::IDX_PULSE_ONE, led_seq_pkg::RST_PULSE_ONE);
    chk_rd(led_seq_pkg::IDX_PULSE_TWO, led_seq_pkg::RST_PULSE_TWO);
    chk_rd(8'h10, 8'h00);
  endtask
  task automatic t_regs();
    wr(led_seq_pkg::IDX_BEHAVIOR_LOW, 8'hE4);
    chk_rd(led_seq_pkg::IDX_BEHAVIOR_LOW, 8'hE4);
    wr(led_seq_pkg::IDX_BEHAVIOR_HIGH, 8'h1B);
    chk_rd(led_seq_pkg::IDX_BEHAVIOR_HIGH, 8'h1B);
    wr(led_seq_pkg::IDX_PULSE_TWO, 8'hFF);
    chk_rd(led_seq_pkg::IDX_PULSE_TWO, 8'h7F);
    wr(led_seq_pkg::IDX_PULSE_ONE, 8'hFF);
    chk_rd(led_seq_pkg::IDX_PULSE_ONE, 8'hFF);
    wr(8'h10, 8'h55);
    chk_rd(8'h10, 8'h00);
    wr(led_seq_pkg::IDX_BEHAVIOR_LOW, 8'h00);
    wr(led_seq_pkg::IDX_BEHAVIOR_HIGH, 8'h00);
  endtask
  task automatic t_direct();
    pol <= 8'hFF;
    wr(led_seq_pkg::IDX_POLARITY, 8'hFF);
    wr(led_seq_pkg::IDX_DRIVE, 8'h01);
    lit_of(0);
    chk(32'(n), 32'd100);
    // max code 8 is 30 percent in direct mode
    wr(led_seq_pkg::IDX_DUTY, 8'h80);
    lit_of(0);
    chk(32'(n), 32'd30);
    wr(led_seq_pkg::IDX_DUTY, led_seq_pkg::RST_DUTY);
    wr(led_seq_pkg::IDX_DRIVE, 8'h00);
    lit_of(0);
    chk(32'(n), 32'd0);
    pol <= 8'hFE;
    wr(led_seq_pkg::IDX_POLARITY, 8'hFE);
    wr(led_seq_pkg::IDX_DRIVE, 8'h01);
    lit_of(0);
    chk(32'(n), 32'd100);
    chk({31'h0, led[0]}, 32'h0);
    pol <= 8'hFF;
    wr(led_seq_pkg::IDX_POLARITY, 8'hFF);
    wr(led_seq_pkg::IDX_DRIVE, 8'h00);
  endtask
  task automatic t_touch();
    wr(led_seq_pkg::IDX_LINK, 8'h02);
    touch <= 8'h02;
    lit_of(1);
    chk(32'(n), 32'd100);
    touch <= 8'h00;
    lit_of(1);
    chk(32'(n), 32'd0);
    wr(led_seq_pkg::IDX_LINK, 8'h00);
  endtask
  task automatic t_pulse_one();
    wr(led_seq_pkg::IDX_PULSE_ONE, 8'h01);
    wr(led_seq_pkg::IDX_REPEAT, 8'h02);
    wr(led_seq_pkg::IDX_BEHAVIOR_LOW, 8'h01);
    wr(led_seq_pkg::IDX_DRIVE, 8'h01);
    poll(1'b1, 50);
    poll(1'b0, 5 * TICK);
    chk(32'(el >= 2 * TICK - 20 && el <= 3 * TICK + 30), 32'h1);
    lit_of(0);
    chk(32'(n), 32'd0);
    wr(led_seq_pkg::IDX_DRIVE, 8'h00);
    // release-edge start: a set must not start it
    wr(led_seq_pkg::IDX_PULSE_ONE, 8'h81);
    wr(led_seq_pkg::IDX_DRIVE, 8'h01);
    repeat (60) @(posedge clk);
    chk_rd(led_seq_pkg::IDX_STATUS, 8'h00);
    wr(led_seq_pkg::IDX_DRIVE, 8'h00);
    poll(1'b1, 50);
    poll(1'b0, 5 * TICK);
  endtask
  task automatic t_pulse_two();
    wr(led_seq_pkg::IDX_PULSE_TWO, 8'h01);
    wr(led_seq_pkg::IDX_REPEAT, 8'h08);
    wr(led_seq_pkg::IDX_BEHAVIOR_LOW, 8'h02);
    wr(led_seq_pkg::IDX_DRIVE, 8'h01);
    poll(1'b1, 50);
    repeat (3 * TICK) @(posedge clk);
    xfer(led_seq_pkg::IDX_STATUS, 1'b0, 8'h00);
    chk({31'h0, d[0]}, 32'h1);
    wr(led_seq_pkg::IDX_DRIVE, 8'h00);
    poll(1'b0, 5 * TICK);
    chk(32'(el >= TICK - 20 && el <= 2 * TICK + 30), 32'h1);
    lit_of(0);
    chk(32'(n), 32'd0);
  endtask
  task automatic t_breathe();
    mx = 0;
    mn = 200;
    wr(led_seq_pkg::IDX_BREATHE, 8'h02);
    wr(led_seq_pkg::IDX_BEHAVIOR_LOW, 8'h03);
    wr(led_seq_pkg::IDX_DRIVE, 8'h01);
    poll(1'b1, 50);
    for (int w = 0; w < 7; w++) begin
      lit_of(0);
      mx = (n > mx) ? n : mx;
      mn = (n < mn) ? n : mn;
    end
    chk(32'(mx > 60 && mn < 40), 32'h1);
    wr(led_seq_pkg::IDX_DRIVE, 8'h00);
    poll(1'b0, 50);
    lit_of(0);
    chk(32'(n), 32'd0);
  endtask
  initial begin
    rstn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    touch = 8'h00;
    pol = 8'h00;
    clr = 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_regs();
    t_direct();
    t_touch();
    t_pulse_one();
    t_pulse_two();
    t_breathe();
    tally_and_finish();
  end
endmodule // tb_led_behavior_sequencer
bind led_behavior_sequencer led_seq_checker led_seq_checker_i (.REF_CLK_IN(REF_CLK_IN), .RESETN_IN(RESETN_IN),
  .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HREADY_IN(HREADY_IN),
  .HRDATA_OUT(HRDATA_OUT), .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT));
